// ===== hdl/eep_device.sv
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module eep_device
  import eep_pkg::*;
#(
  parameter int         WRITE_CYCLES_P = WRITE_CYCLES,
  // Device type code; value is arbitrary
  parameter logic [3:0] DEVICE_CODE    = 4'h5
) (
  // Clock and reset
  input  wire logic              MCLK_I,
  input  wire logic              RST_N_I,
  // Two-wire bus
  eep_if.dev                     BUS,
  // Strap and protect pins
  input  wire logic [CS_W-1:0]   CS_I,
  input  wire logic              WP_I,
  // Array write port
  output logic                   BUSY_O,
  output logic                   WR_EN_O,
  output logic [ADDR_W-1:0]      WR_ADDR_O,
  output logic [7:0]             WR_DATA_O
);

  localparam int TW = $clog2(WRITE_CYCLES_P + 1);

  logic              scl_m, scl_s, scl_d;   // Clock line synchroniser
  logic              sda_m, sda_s, sda_d;   // Data line synchroniser
  logic [CS_W-1:0]   cs_m, cs_s;            // Select pin synchroniser
  logic              wp_m, wp_s;            // Protect pin synchroniser
  logic              rise, fall;            // Bus clock edges
  logic              start_c, stop_c;       // Bus conditions
  logic [3:0]        bit_cnt;               // Bits seen in this slot
  logic [7:0]        shift;                 // Received byte
  eep_dev_state_type state;                 // Byte phase
  logic              ack;                   // Pulling data low
  logic [ADDR_W-1:0] ptr;                   // Address pointer
  logic [7:0]        page [0:PAGE_BYTES-1]; // Page buffer
  logic [PAGE_BYTES-1:0] valid;             // Buffered byte marks
  logic              byte_done;             // Byte received, ack clock next
  logic              commit;                // Write cycle starts
  logic              busy;                  // Write cycle running
  logic [TW-1:0]     timer;                 // Write cycle clock count
  logic [ADDR_W-PAGE_W-1:0] wr_page;        // Page under commit
  logic              cycle_end;             // Last write cycle clock

  assign BUS.d_sda_o  = 1'b0;
  assign BUS.d_sda_oe = ack;

  // Two flops on every outside input except the reset before any logic
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      cs_m  <= '0;
      cs_s  <= '0;
      wp_m  <= 1'b0;
      wp_s  <= 1'b0;
    end else begin
      scl_m <= BUS.scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= BUS.sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
      cs_m  <= CS_I;
      cs_s  <= cs_m;
      wp_m  <= WP_I;
      wp_s  <= wp_m;
    end
  end

  // Edge and condition detection on synchronised lines
  always_comb begin
    rise    = scl_s & ~scl_d;
    fall    = ~scl_s & scl_d;
    start_c = scl_s & scl_d & sda_d & ~sda_s;
    stop_c  = scl_s & scl_d & ~sda_d & sda_s;
    byte_done = fall && bit_cnt == BIT_ACK && state != DS_HOLD
                && state != DS_IDLE;
    cycle_end = busy && timer == TW'(WRITE_CYCLES_P - 1);
  end

  // Only a protect-low STOP after data starts a cycle
  // commit at STOP
  always_comb begin
    commit = stop_c && state == DS_DATA && |valid && !wp_s;
  end

  // Bit counter and shift register
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      bit_cnt <= '0;
      shift   <= '0;
    end else if (start_c || stop_c) begin
      bit_cnt <= '0;
    end else if (rise && bit_cnt < BIT_ACK) begin
      shift   <= {shift[6:0], sda_s};
      bit_cnt <= bit_cnt + 4'h1;
    end else if (rise && bit_cnt == BIT_ACK) begin
      bit_cnt <= BIT_END;
    end else if (fall && bit_cnt == BIT_END) begin
      bit_cnt <= '0;
    end
  end

  // Byte phase, acknowledge and address pointer
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      state <= DS_IDLE;
      ack   <= 1'b0;
      ptr   <= '0;
    end else if (start_c) begin
      state <= DS_CTRL;
      ack   <= 1'b0;
    end else if (stop_c) begin
      state <= DS_IDLE;
      ack   <= 1'b0;
    end else if (fall && bit_cnt == BIT_END) begin
      // Release after the ninth clock
      ack <= 1'b0;
    end else if (byte_done) begin
      case (state)
        DS_CTRL: begin
          if (shift[7:4] == DEVICE_CODE && shift[3:1] == cs_s
              && !busy) begin
            ack <= 1'b1;
            state <= shift[0] ? DS_HOLD : DS_AHI;
          end else begin
            state <= DS_HOLD;
          end
        end
        DS_AHI: begin
          // high byte, top two bits dropped
          ptr[ADDR_W-1:8] <= shift[ADDR_W-9:0];
          ack   <= 1'b1;
          state <= DS_ALO;
        end
        DS_ALO: begin
          ptr[7:0] <= shift;
          ack   <= 1'b1;
          state <= DS_DATA;
        end
        DS_DATA: begin
          ptr[PAGE_W-1:0] <= ptr[PAGE_W-1:0] + 6'h01;
          ack <= 1'b1;
        end
        default: begin
          state <= DS_HOLD;
        end
      endcase
    end
  end

  // Page buffer storage
  // overrun overwrites earlier bytes
  always_ff @(posedge MCLK_I) begin
    if (byte_done && state == DS_DATA) begin
      page[ptr[PAGE_W-1:0]] <= shift;
    end
  end

  // Buffered byte marks; dropped on abandon or protect
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      valid <= '0;
    end else if (cycle_end) begin
      valid <= '0;
    end else if (!busy && ((start_c && state == DS_DATA)
                 || (stop_c && !commit))) begin
      valid <= '0;
    end else if (byte_done && state == DS_DATA) begin
      valid[ptr[PAGE_W-1:0]] <= 1'b1;
    end
  end

  // Self-timed write cycle
  // fixed length, within the limit
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      busy    <= 1'b0;
      timer   <= '0;
      wr_page <= '0;
    end else if (commit && !busy) begin
      busy    <= 1'b1;
      timer   <= '0;
      wr_page <= ptr[ADDR_W-1:PAGE_W];
    end else if (cycle_end) begin
      busy <= 1'b0;
    end else if (busy) begin
      timer <= timer + TW'(1);
    end
  end

  // Array write strobes, one buffered byte per clock
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      WR_EN_O   <= 1'b0;
      WR_ADDR_O <= '0;
      WR_DATA_O <= '0;
    end else if (busy && timer < TW'(PAGE_BYTES)) begin
      WR_EN_O   <= valid[timer[PAGE_W-1:0]];
      WR_ADDR_O <= {wr_page, timer[PAGE_W-1:0]};
      WR_DATA_O <= page[timer[PAGE_W-1:0]];
    end else begin
      WR_EN_O <= 1'b0;
    end
  end

  // Busy flag seen by the user side
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      BUSY_O <= 1'b0;
    end else begin
      BUSY_O <= busy;
    end
  end

endmodule

// ===== hdl/eep_pkg.sv
package eep_pkg;
  // Clock and derived timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // Longest self-timed write cycle, in microseconds
  localparam int WRITE_TIME_US = 5000;
  localparam int WRITE_CYCLES  = WRITE_TIME_US * (CLK_HZ / 1_000_000);
  // Quarter of a bus clock period made by the controller
  localparam int QTR_TIME_NS   = 2500;
  localparam int QTR_CYCLES    = QTR_TIME_NS / CLK_PERIOD_NS;
  localparam int QTR_W         = $clog2(QTR_CYCLES);

  // Word address and page geometry
  localparam int ADDR_W     = 14;
  localparam int PAGE_W     = 6;
  localparam int PAGE_BYTES = 64;
  localparam int CS_W       = 3;
  localparam int CODE_W     = 4;

  // Bit counter marks within one nine-clock byte slot
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;

  // Controller registers on the AHB-Lite side
  localparam logic [31:0] CMD_OFS  = 32'h0000_0000;
  localparam logic [31:0] STAT_OFS = 32'h0000_0004;
  localparam int CMD_START_BIT  = 8;
  localparam int CMD_STOP_BIT   = 9;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_NACK_BIT  = 1;

  // Device byte phases, Gray coded along the write path
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_CTRL = 3'h1,
    DS_AHI  = 3'h3,
    DS_ALO  = 3'h2,
    DS_DATA = 3'h6,
    DS_HOLD = 3'h7
  } eep_dev_state_type;

  // Controller line phases
  typedef enum logic [1:0] {
    MS_IDLE  = 2'h0,
    MS_START = 2'h1,
    MS_BIT   = 2'h3,
    MS_STOP  = 2'h2
  } eep_mst_state_type;
endpackage

// ===== hdl/eep_if.sv
`timescale 1ns/1ps
interface eep_if;
  logic scl;        // Bus clock, driven by the controller
  logic m_sda_o;    // Controller data out, always low
  logic m_sda_oe;   // Controller pulls data low
  logic d_sda_o;    // Device data out, always low
  logic d_sda_oe;   // Device pulls data low
  logic sda;        // Resolved open-drain data line

  // Pull-up wins unless someone pulls low
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
  modport host (output scl, input sda, output m_sda_o, output m_sda_oe);
endinterface

// ===== hdl/eep_host.sv
`timescale 1ns/1ps
module eep_host
  import eep_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RST_N_I,
  // Two-wire bus
  eep_if.host              BUS,
  // AHB-Lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic [31:0]      HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O
);

  logic [QTR_W-1:0]  div;      // Quarter period divider
  logic              tick;     // One-cycle quarter enable
  logic              sda_m;    // Data line synchroniser
  logic              sda_s;
  eep_mst_state_type state;    // Line phase
  logic [1:0]        qtr;      // Quarter within a phase
  logic [3:0]        bit_cnt;  // Bit within a byte slot
  logic [7:0]        tx;       // Byte being sent
  logic              want_stop;
  logic              busy;     // Command in progress
  logic              nack;     // Last slot not acknowledged
  logic              scl;      // Clock level driven
  logic              pull;     // Pulling data low
  logic              wr_pend;  // Write data phase next
  logic [31:0]       addr;     // Address of that write
  logic              cmd_wr;   // Command register written

  assign BUS.scl      = scl;
  assign BUS.m_sda_o  = 1'b0;
  assign BUS.m_sda_oe = pull;

  // Quarter ticks from the system clock
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I || tick) begin
      div <= '0;
    end else begin
      div <= div + QTR_W'(1);
    end
  end

  always_comb begin
    tick   = div == QTR_W'(QTR_CYCLES - 1);
    cmd_wr = wr_pend && addr == CMD_OFS;
  end

  // Data line is outside our clock domain
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_m <= BUS.sda;
      sda_s <= sda_m;
    end
  end

  // AHB-Lite address and data phases, zero wait states
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      wr_pend     <= 1'b0;
      addr        <= '0;
      HRDATA_O    <= '0;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      wr_pend <= HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
      addr    <= HADDR_I;
      HRDATA_O <= '0;
      if (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I
          && HADDR_I == STAT_OFS) begin
        // Pending command counts as busy already
        HRDATA_O[STAT_BUSY_BIT] <= busy | cmd_wr;
        HRDATA_O[STAT_NACK_BIT] <= nack;
      end
    end
  end

  // Line sequencer: START, nine-clock slots, STOP
  // framing conditions while clock high
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      state     <= MS_IDLE;
      qtr       <= '0;
      bit_cnt   <= '0;
      tx        <= '0;
      want_stop <= 1'b0;
      busy      <= 1'b0;
      nack      <= 1'b0;
      scl       <= 1'b1;
      pull      <= 1'b0;
    end else if (cmd_wr && !busy) begin
      // Commands while busy are dropped
      tx        <= HWDATA_I[7:0];
      want_stop <= HWDATA_I[CMD_STOP_BIT];
      busy      <= 1'b1;
      qtr       <= '0;
      bit_cnt   <= '0;
      state     <= HWDATA_I[CMD_START_BIT] ? MS_START : MS_BIT;
    end else if (tick && busy) begin
      qtr <= qtr + 2'h1;
      case (state)
        MS_START: begin
          case (qtr)
            2'h0: pull <= 1'b0;
            2'h1: scl <= 1'b1;
            2'h2: pull <= 1'b1;
            default: begin
              scl   <= 1'b0;
              state <= MS_BIT;
            end
          endcase
        end
        MS_BIT: begin
          case (qtr)
            // Ones shifted in release the line for the ack
            2'h0: pull <= ~tx[7];
            2'h1: scl <= 1'b1;
            2'h2: begin
              if (bit_cnt == BIT_ACK) begin
                // ack expected in the ninth clock
                nack <= sda_s;
              end
            end
            default: begin
              scl     <= 1'b0;
              tx      <= {tx[6:0], 1'b1};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == BIT_ACK) begin
                state <= want_stop ? MS_STOP : MS_IDLE;
                busy  <= want_stop;
              end
            end
          endcase
        end
        MS_STOP: begin
          case (qtr)
            2'h0: pull <= 1'b1;
            2'h1: scl <= 1'b1;
            default: begin
              pull  <= 1'b0;
              busy  <= 1'b0;
              state <= MS_IDLE;
            end
          endcase
        end
        default: begin
          state <= MS_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ===== bench/eep_properties.sv
`timescale 1ns/1ps
module eep_properties
  import eep_pkg::*;
#(
  parameter int WC = 250000
) (
  // Clock and reset
  input wire logic              MCLK_I,
  input wire logic              RST_N_I,
  // Two-wire bus
  input wire logic              scl,
  input wire logic              m_sda_oe,
  input wire logic              d_sda_oe,
  // Device array side
  input wire logic              BUSY_O,
  input wire logic              WR_EN_O,
  input wire logic [ADDR_W-1:0] WR_ADDR_O
);
  int unsigned bcnt;   // Cycles spent in the current write cycle
  logic [7:0]  pg;     // Page of the first strobe in this cycle
  logic        pg_ok;  // A strobe was seen in this cycle

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  // Length of the write cycle; a stuck timer shows up here
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I || !BUSY_O) begin
      bcnt <= 0;
    end else begin
      bcnt <= bcnt + 1;
    end
  end

  // Page seen at the first array strobe of a cycle
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I || !BUSY_O) begin
      pg_ok <= 1'b0;
    end else if (WR_EN_O && !pg_ok) begin
      pg_ok <= 1'b1;
      pg    <= WR_ADDR_O[13:6];
    end
  end

  busy_no_ack_a:
    assert property (BUSY_O |-> !d_sda_oe)
    else $error("Ack driven during write cycle");
  commit_in_cycle_a:
    assert property (WR_EN_O |-> BUSY_O)
    else $error("Array strobe outside write cycle");
  cycle_bound_a:
    assert property (BUSY_O |-> bcnt < WC + 2)
    else $error("Write cycle too long");
  page_kept_a:
    assert property (WR_EN_O && pg_ok |-> WR_ADDR_O[13:6] == pg)
    else $error("Page write left its page");
  ack_hold_a:
    assert property (scl && $past(scl) |-> $stable(d_sda_oe))
    else $error("Ack changed while clock high");
  ack_setup_a:
    assert property ($rose(d_sda_oe) |-> (!scl) [*8])
    else $error("Ack raised too near clock high");
  start_frame_a:
    assert property ($rose(m_sda_oe) && scl |-> ##[1:130] !scl)
    else $error("Start not followed by clock low");
  idle_reset_a:
    assert property ($rose(RST_N_I) |-> scl && !m_sda_oe && !BUSY_O)
    else $error("Bus not idle after reset");
endmodule

// ===== bench/serial_eeprom_addressing_write_test.sv
`timescale 1ns/1ps
module serial_eeprom_addressing_write_test
  import eep_pkg::*;
;
  localparam int WC = 6000;            // Outlasts one poll byte
  localparam logic [3:0] CODE = 4'h5;  // Device code, value arbitrary
  logic        clk = 0;
  logic        rst_n = 0;
  logic        hsel = 0;               // AHB master side
  logic        hwrite = 0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [2:0]  cs = 3'h0;              // Select straps
  logic        wp = 1'b0;              // Protect pin
  logic        busy;
  logic        wr_en;
  logic [13:0] wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  ctl;                    // Write control byte
  logic [7:0]  ed [0:7];               // Data sent in a frame
  logic [7:0]  mem [int];              // Array contents seen
  int n_mismatch = 0;
  int n_tests = 0;
  int n_wr = 0;                        // Array strobes
  int n_ack = 0;                       // Acks seen on the wire
  int n_start = 0;                     // Starts seen on the wire

  eep_if bus();
  eep_device #(.WRITE_CYCLES_P(WC), .DEVICE_CODE(CODE)) eep_device_inst (
    .MCLK_I(clk), .RST_N_I(rst_n), .BUS(bus), .CS_I(cs), .WP_I(wp),
    .BUSY_O(busy), .WR_EN_O(wr_en), .WR_ADDR_O(wr_addr),
    .WR_DATA_O(wr_data));
  eep_host eep_host_inst (
    .MCLK_I(clk), .RST_N_I(rst_n), .BUS(bus), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp));
  eep_properties #(.WC(WC)) eep_properties_inst (
    .MCLK_I(clk), .RST_N_I(rst_n), .scl(bus.scl),
    .m_sda_oe(bus.m_sda_oe), .d_sda_oe(bus.d_sda_oe),
    .BUSY_O(busy), .WR_EN_O(wr_en), .WR_ADDR_O(wr_addr));

  initial begin
    forever #10 clk = ~clk;
  end

  // Wire monitors: array strobes, device acks, start conditions
  always @(posedge clk) begin
    if (wr_en === 1'b1) begin
      mem[wr_addr] = wr_data;
      n_wr++;
    end
  end
  always @(posedge bus.d_sda_oe) n_ack++;
  always @(negedge bus.sda) begin
    if (bus.scl === 1'b1) begin
      n_start++;
    end
  end

  task check(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask

  // One single AHB transfer; waits on hready, never on a fixed count
  task ahb(input logic w, input logic [31:0] a, d,
           output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    check(hresp, 1'b0);
    // Select stays up between transfers; IDLE htrans ends each one
  endtask

  // One byte slot on the link, then the ack result from status
  task sb(input logic [7:0] b, input logic st, sp, output logic nk);
    logic [31:0] r;
    ahb(1'b1, CMD_OFS, {22'h00_0000, sp, st, b}, r);
    do ahb(1'b0, STAT_OFS, 32'h0000_0000, r);
    while (r[STAT_BUSY_BIT] !== 1'b0);
    nk = r[STAT_NACK_BIT];
  endtask

  // Expected array address of the k-th byte of a frame
  function automatic logic [13:0] exp_addr(input logic [7:0] hi, lo,
                                           input int k);
    return {hi[5:0], lo[7:6], 6'(lo[5:0] + k)};
  endfunction

  // Write frame: control, high and low address, n data bytes, stop
  task wr_cmd(input logic [7:0] hi, lo, input int n);
    logic nk;
    sb(ctl, 1'b1, 1'b0, nk);
    check(nk, 1'b0);
    sb(hi, 1'b0, 1'b0, nk);
    check(nk, 1'b0);
    sb(lo, 1'b0, 1'b0, nk);
    check(nk, 1'b0);
    for (int i = 0; i < n; i++) begin
      ed[i] = 8'($urandom);
      sb(ed[i], 1'b0, i == n - 1, nk);
      check(nk, 1'b0);
    end
  endtask

  task end_sim;
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog at one hundred thousand clocks, above the roughly seventy-five thousand of traffic
  initial begin
    #2_000_000;
    n_mismatch++;
    $display("ERROR %0t: run did not finish", $time);
    end_sim();
  end

  initial begin
    logic [7:0] hi;
    logic [7:0] lo;
    logic nk;
    int k;
    k = $urandom(13);
    ctl = {CODE, 3'($urandom), 1'b0};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cs    <= ctl[3:1];
    repeat (4) @(posedge clk);
    // Page write starting two bytes before page end, junk top bits
    hi = 8'($urandom);
    lo = {2'($urandom), 6'h3E};
    wr_cmd(hi, lo, 3);
    // Protect raised just after STOP must not cancel the cycle
    wp <= 1'b1;
    // Poll at once: still in the write cycle, so no ack
    sb(ctl, 1'b1, 1'b1, nk);
    check(nk, 1'b1);
    k = 0;
    do begin
      sb(ctl, 1'b1, 1'b1, nk);
      k++;
    end while (nk && k < 4);
    wp <= 1'b0;
    check(nk, 1'b0);
    check(n_wr, 3);
    for (int i = 0; i < 3; i++) begin
      check(mem[exp_addr(hi, lo, i)], ed[i]);
    end
    check(n_start, 2 + k);
    // Wrong select bits get no ack; read control byte is acked
    sb({CODE, ~cs, 1'b0}, 1'b1, 1'b1, nk);
    check(nk, 1'b1);
    sb({CODE, cs, 1'b1}, 1'b1, 1'b1, nk);
    check(nk, 1'b0);
    // Protected write: all acked, nothing stored, ready at once
    wp <= 1'b1;
    wr_cmd(8'($urandom), 8'($urandom), 1);
    sb(ctl, 1'b1, 1'b1, nk);
    wp <= 1'b0;
    check(nk, 1'b0);
    check(n_wr, 3);
    check(n_ack, 13);
    end_sim();
  end
endmodule
